/* File: rtl/rsc_strap_loader.sv */
// Reset-time strap sampling and configuration source selection
// How it works
// - Link power-good low resets chip, one microsecond
// - Test select sampled at reset release
// - External memory strap enables EEPROM configuration load
// - Serial strap enables SMBus or SPI configuration
// - Both pullups give SMBus, else SPI
// - Straps latched at power-on and chip reset release
// - Pins use default function until configuration done
`timescale 1ns/1ps
`default_nettype none
module rsc_strap_loader (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       chip_reset_low,
  input  wire logic                       link_power_clock_good_low,
  input  wire logic                       test_mode_select,
  input  wire logic                       eeprom_strap,
  input  wire logic                       serial_select_strap,
  input  wire logic                       clock_line_pullup_strap,
  input  wire logic                       data_line_pullup_strap,
  input  wire logic                       config_done,
  input  wire logic [rsc_pkg::FUNC_W-1:0] fw_pin_function [rsc_pkg::PIN_COUNT],
  output logic                            device_in_reset,
  output logic                            test_mode_enable,
  output logic                            eeprom_load_enable,
  output logic                            serial_config_enable,
  output logic [1:0]                      serial_if_select,
  output logic                            config_complete,
  output logic [rsc_pkg::FUNC_W-1:0]      programmable_function_pins [rsc_pkg::PIN_COUNT]
);
  import rsc_pkg::*;

  logic       chip_in_rst;
  logic       chip_rel;
  logic       link_in_rst;
  logic       link_rel;
  logic       any_rst;
  logic       any_hold;
  logic       take_sample;
  logic       in_config;
  logic       in_run;
  logic       both_pullups;
  logic       pins_default;
  rsc_state_t state_reg;
  rsc_state_t state_next;
  logic       test_reg;
  logic       eeprom_reg;
  logic       serial_reg;
  logic [1:0] if_sel_reg;
  logic [1:0] if_sel_next;
  logic       done_reg;
  logic       done_next;

  // Qualified chip reset input
  rsc_reset_filter u_chip_filter (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .rst_low       (chip_reset_low),
    .in_reset      (chip_in_rst),
    .release_pulse (chip_rel)
  );

  // Qualified link power-good input
  rsc_reset_filter u_link_filter (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .rst_low       (link_power_clock_good_low),
    .in_reset      (link_in_rst),
    .release_pulse (link_rel)
  );

  assign any_rst = chip_in_rst | link_in_rst;

  // Held by an input that is still low, so one release alone cannot start
  assign any_hold = (chip_in_rst && !chip_rel) ||
                    (link_in_rst && !link_rel);

  // Loader sequence
  always_comb begin
    state_next = state_reg;
    if (any_hold) begin
      state_next = RSC_ST_RESET;
    end else begin
      case (state_reg)
        RSC_ST_RESET: begin
          state_next = RSC_ST_SAMPLE;
        end
        RSC_ST_SAMPLE: begin
          state_next = RSC_ST_CONFIG;
        end
        RSC_ST_CONFIG: begin
          if (config_done) begin
            state_next = RSC_ST_RUN;
          end
        end
        RSC_ST_RUN: begin
          state_next = RSC_ST_RUN;
        end
        default: begin
          state_next = RSC_ST_RESET;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= RSC_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Decoded loader state
  assign take_sample = (state_reg == RSC_ST_SAMPLE);
  assign in_config   = (state_reg == RSC_ST_CONFIG);
  assign in_run      = (state_reg == RSC_ST_RUN);

  // Interface choice from the pull-up straps
  assign both_pullups = clock_line_pullup_strap && data_line_pullup_strap;

  always_comb begin
    if_sel_next = SER_NONE;
    if (serial_select_strap) begin
      if (both_pullups) begin
        if_sel_next = SER_SMBUS;
      end else begin
        if_sel_next = SER_SPI;
      end
    end
  end

  // Test select capture
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      test_reg <= 1'b0;
    end else if (take_sample) begin
      test_reg <= test_mode_select;
    end
  end

  // External memory strap capture
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      eeprom_reg <= 1'b0;
    end else if (take_sample) begin
      eeprom_reg <= eeprom_strap;
    end
  end

  // Serial strap capture
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_reg <= 1'b0;
    end else if (take_sample) begin
      serial_reg <= serial_select_strap;
    end
  end

  // Serial interface choice capture
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      if_sel_reg <= SER_NONE;
    end else if (take_sample) begin
      if_sel_reg <= if_sel_next;
    end
  end

  // Configuration completion flag
  always_comb begin
    done_next = in_run;
    if (in_config && config_done && !any_rst) begin
      done_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
    end
  end

  // Default pin function while reset or unconfigured
  assign pins_default = any_rst || !done_reg;

  // Pin function select, default until configured
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          programmable_function_pins[gi] <= DEFAULT_PIN_FUNCTION;
        end else if (pins_default) begin
          programmable_function_pins[gi] <= DEFAULT_PIN_FUNCTION;
        end else begin
          programmable_function_pins[gi] <= fw_pin_function[gi];
        end
      end
    end
  endgenerate

  // Outputs
  assign device_in_reset      = (state_reg == RSC_ST_RESET);
  assign test_mode_enable     = test_reg;
  assign eeprom_load_enable   = eeprom_reg && in_config;
  assign serial_config_enable = serial_reg && in_config;
  assign serial_if_select     = if_sel_reg;
  assign config_complete      = done_reg;
endmodule // rsc_strap_loader
`default_nettype wire

/* File: shared/rsc_pkg.sv */
// Shared constants for the reset strap configuration selector
package rsc_pkg;
  // Reset pulse minimum on either reset input
  localparam int unsigned CLK_FREQ_HZ     = 50_000_000;
  localparam int unsigned RST_MIN_PULSE_US = 1;
  localparam int unsigned RST_MIN_CYCLES  =
    (RST_MIN_PULSE_US * CLK_FREQ_HZ + 999_999) / 1_000_000;
  localparam int unsigned RST_CNT_W       = 8;
  // Programmable function pins
  localparam int unsigned PIN_COUNT       = 48;
  localparam int unsigned FUNC_W          = 4;
  localparam logic [3:0]  DEFAULT_PIN_FUNCTION = 4'h0;
  // Serial configuration interface encoding
  localparam logic [1:0]  SER_NONE        = 2'h0;
  localparam logic [1:0]  SER_SMBUS       = 2'h1;
  localparam logic [1:0]  SER_SPI         = 2'h2;
  // Loader states
  typedef enum logic [3:0] {
    RSC_ST_RESET   = 4'h1,
    RSC_ST_SAMPLE  = 4'h2,
    RSC_ST_CONFIG  = 4'h4,
    RSC_ST_RUN     = 4'h8
  } rsc_state_t;
endpackage

/* File: rtl/rsc_reset_filter.sv */
// Reset pulse qualifier: accepts low pulses of at least the minimum width
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_filter (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic rst_low,
  output logic      in_reset,
  output logic      release_pulse
);
  import rsc_pkg::*;

  logic [RST_CNT_W-1:0] low_cnt_reg;
  logic                 held_reg;

  // Count width of the low pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_reg <= '0;
    end else if (rst_low) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != RST_CNT_W'(RST_MIN_CYCLES)) begin
      low_cnt_reg <= low_cnt_reg + RST_CNT_W'(1);
    end
  end

  // Qualified reset held until rising edge of the input
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      held_reg <= 1'b1;
    end else if (!rst_low && low_cnt_reg == RST_CNT_W'(RST_MIN_CYCLES - 1)) begin
      held_reg <= 1'b1;
    end else if (rst_low) begin
      held_reg <= 1'b0;
    end
  end

  assign in_reset      = held_reg;
  assign release_pulse = held_reg && rst_low;
endmodule // rsc_reset_filter
`default_nettype wire

/* File: test/rsc_fw_model.sv */
// Firmware and board model answering the loader
`timescale 1ns/1ps
`default_nettype none
module rsc_fw_model (
  input  wire logic clk, device_in_reset, eeprom_load_enable,
  input  wire logic [1:0] serial_if_select,
  output logic config_done,
  output logic [rsc_pkg::FUNC_W-1:0] fw_pin_function [rsc_pkg::PIN_COUNT]
);
  import rsc_pkg::*;
  logic [3:0] cnt_reg, fn_reg;
  always_ff @(posedge clk) begin
    cnt_reg <= device_in_reset ? 4'h0 : cnt_reg + 4'(cnt_reg != 4'hf);
    if (cnt_reg == 4'h4) fn_reg <= eeprom_load_enable ? 4'h4 : 4'(serial_if_select) + 4'h1;
  end
  assign config_done = cnt_reg > 4'h9;
  always_comb for (int i = 0; i < PIN_COUNT; i++) fw_pin_function[i] = fn_reg;
endmodule // rsc_fw_model
`default_nettype wire

/* File: test/rsc_strap_checker.sv */
// Port assertions for the strap loader
`timescale 1ns/1ps
`default_nettype none
module rsc_strap_checker (
  input wire logic clk, sys_rst, chip_reset_low, link_power_clock_good_low, test_mode_select,
  input wire logic eeprom_strap, serial_select_strap, clock_line_pullup_strap,
  input wire logic data_line_pullup_strap, device_in_reset, test_mode_enable,
  input wire logic eeprom_load_enable, serial_config_enable, config_complete,
  input wire logic [1:0] serial_if_select,
  input wire logic [rsc_pkg::FUNC_W-1:0] programmable_function_pins [rsc_pkg::PIN_COUNT]
);
  import rsc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_rel; $fell(device_in_reset); endsequence
  property p_tst; s_rel |=> test_mode_enable == $past(test_mode_select); endproperty
  a_tst: assert property (p_tst) else $error("test mode");
  property p_eep; $rose(eeprom_load_enable) |-> $past(eeprom_strap); endproperty
  a_eep: assert property (p_eep) else $error("eeprom");
  property p_ser; $rose(serial_config_enable) |-> $past(serial_select_strap); endproperty
  a_ser: assert property (p_ser) else $error("serial");
  property p_sel; s_rel |=> serial_if_select == (!$past(serial_select_strap) ? SER_NONE :
    ($past(clock_line_pullup_strap) && $past(data_line_pullup_strap)) ? SER_SMBUS : SER_SPI);
  endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_hold; !device_in_reset && !$fell(device_in_reset) |=>
    $stable(serial_if_select) && $stable(test_mode_enable); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_def; !config_complete && !$fell(config_complete) |->
    programmable_function_pins[0] == DEFAULT_PIN_FUNCTION; endproperty
  a_def: assert property (p_def) else $error("default");
  property p_rst; $rose(device_in_reset) |->
    !$past(chip_reset_low, 40) || !$past(link_power_clock_good_low, 40); endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_cpl; config_complete |=> config_complete || device_in_reset; endproperty
  a_cpl: assert property (p_cpl) else $error("complete");
endmodule // rsc_strap_checker
bind rsc_strap_loader rsc_strap_checker i_rsc_strap_checker (.*);
`default_nettype wire

/* File: test/rsc_strap_loader_bench.sv */
// Bench for the strap loader
`timescale 1ns/1ps
`default_nettype none
module rsc_strap_loader_bench;
  import rsc_pkg::*;
  logic clk = 0, sys_rst = 1, chip_reset_low = 1, link_power_clock_good_low = 1;
  logic test_mode_select, eeprom_strap, serial_select_strap, clock_line_pullup_strap;
  logic data_line_pullup_strap, config_done, device_in_reset, test_mode_enable;
  logic eeprom_load_enable, serial_config_enable, config_complete;
  logic [1:0] serial_if_select, e;
  logic [FUNC_W-1:0] fw_pin_function [PIN_COUNT], programmable_function_pins [PIN_COUNT];
  int miscompares = 0, check_count = 0;
  always #10 clk = ~clk;
  rsc_strap_loader i_rsc_strap_loader (.*);
  rsc_fw_model i_rsc_fw_model (.*);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(input logic [4:0] s);
    {test_mode_select, eeprom_strap, serial_select_strap, clock_line_pullup_strap,
      data_line_pullup_strap} = s;
  endtask
  task automatic chk(input string n, input logic [3:0] g, x);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic stop_test;
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_boot(input logic [4:0] s, input logic lnk);
    e = s[2] ? (s[1] & s[0] ? SER_SMBUS : SER_SPI) : SER_NONE;
    put(s);
    if (lnk) link_power_clock_good_low = 0;
    else chip_reset_low = 0;
    tick(60);
    chk("rst", device_in_reset, 1);
    chk("def", programmable_function_pins[9], DEFAULT_PIN_FUNCTION);
    {chip_reset_low, link_power_clock_good_low} = 2'h3;
    tick(4);
    chk("tst", test_mode_enable, s[4]);
    chk("eep", eeprom_load_enable, s[3]);
    chk("ser", serial_config_enable, s[2]);
    put(~s);
    tick(20);
    chk("sel", serial_if_select, e);
    chk("pin", programmable_function_pins[47], s[3] ? 4'h4 : 4'(e) + 4'h1);
    chk("cpl", config_complete, 1);
  endtask
  task automatic t_overlap;
    {chip_reset_low, link_power_clock_good_low} = 2'h0;
    tick(60);
    chip_reset_low = 1;
    tick(4);
    chk("ovl", device_in_reset, 1);
    link_power_clock_good_low = 1;
    tick(4);
    chk("rel", device_in_reset, 0);
  endtask
  task automatic t_short;
    chip_reset_low = 0;
    tick(10);
    chip_reset_low = 1;
    tick(3);
    chk("short", device_in_reset, 0);
    chk("kept", config_complete, 1);
  endtask
  initial begin
    put(5'h00);
    tick(6);
    sys_rst = 0;
    tick(30);
    t_short;
    t_overlap;
    t_boot(5'h17, 0);
    t_boot(5'h0e, 1);
    t_boot(5'h0d, 0);
    t_boot(5'h08, 1);
    t_boot(5'h1f, 1);
    stop_test;
  end
  initial begin
    #100000;
    miscompares++;
    stop_test;
  end
endmodule // rsc_strap_loader_bench
`default_nettype wire
